// ---- verilog/wake_ctrl.sv ----
// Interrupt wake, coalescing and debug hold control with a Wishbone slave.
//
// Summary of operation
// - Every register returns to its reset value on any device, power-on or watchdog reset.
// - In Sleep only sources still running in Sleep are accepted.
// - Disabled or zero-priority requests are ignored and never change power state.
// - In Sleep, enabled request above processor priority wakes device to Run.
// - In Sleep, coalesced low request goes to Idle, then Run after timeout.
// - In Sleep, request at or below processor priority wakes only to Idle.
// - In Idle, request above processor priority moves device to Run.
// - In Idle, coalesced request stays in Idle, withheld until timer expires.
// - In Idle, request at or below processor priority stays pending in Idle.
// - During debug halt no interrupt is delivered; all requests stay pending.
// - After debug exit, pending requests are delivered highest priority first.
// - Freeze bit is accessible only in debug; otherwise reads zero, ignores writes.
// - A freeze write takes effect only at the next debug entry.
// - In debug, freeze reads the state in force at debug entry.
// - At timer expiry the highest priority queued request is presented first.
// - Delivery needs global enable, source enable and non-zero priority.
// - Coalescing priority zero disables the proximity timer entirely.
// - Timer loads 32-bit reload value, counts down, releases queue at zero.
`timescale 1ns/1ps

module wake_ctrl
    import wake_ctrl_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone classic slave.
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [4:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic [31:0]               dat_o,
    output logic                      ack_o,
    // Sources.
    input  wire logic [NUM_SRC-1:0]   src_req_i,
    input  wire logic [NUM_SRC-1:0]   src_sleep_ok_i,
    // Processor core and power manager.
    input  wire logic                 global_ie_i,
    input  wire logic [PRIO_W-1:0]    cpu_ipl_i,
    input  wire logic                 debug_mode_i,
    input  wire logic [1:0]           power_mode_i,
    output logic                      irq_o,
    output logic [SRC_ID_W-1:0]       irq_id_o,
    output logic [PRIO_W-1:0]         irq_prio_o,
    output logic                      wake_idle_o,
    output logic                      wake_run_o,
    output logic                      freeze_o
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [PRIO_W-1:0]   coalescing_priority_q;
    logic [TIMER_W-1:0]  proximity_reload_value_q;
    logic [TIMER_W-1:0]  proximity_timeout_q;
    logic [NUM_SRC-1:0]  enable_q;
    logic [31:0]         source_priority_regs_q;
    logic [NUM_SRC-1:0]  flag_q;
    logic                freeze_cfg_q;
    logic                freeze_live_q;
    logic                debug_prev_q;
    tmr_state_t          tmr_state_q;
    tmr_state_t          tmr_state_d;
    logic [TIMER_W-1:0]  timer_d;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire        bus_req    = cyc_i & stb_i & ~ack_o;
    wire        bus_wr     = bus_req & we_i;
    wire        hit_ctrl   = (adr_i == OFS_CTRL);
    wire        hit_reload = (adr_i == OFS_RELOAD);
    wire        hit_enable = (adr_i == OFS_ENABLE);
    wire        hit_prio   = (adr_i == OFS_PRIO);
    wire        hit_pend   = (adr_i == OFS_PEND);
    wire [31:0] byte_mask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] wr_data    = dat_i & byte_mask;

    // Control word merged with byte enables so partial writes keep other bytes.
    wire [31:0] ctrl_now   = {17'h00000, freeze_cfg_q, 11'h000, coalescing_priority_q};
    wire [31:0] ctrl_merge = (ctrl_now & ~byte_mask) | wr_data;
    wire [31:0] rel_merge  = (proximity_reload_value_q & ~byte_mask) | wr_data;
    wire [31:0] prio_merge = (source_priority_regs_q & ~byte_mask) | wr_data;
    wire [31:0] en_merge   = ({24'h000000, enable_q} & ~byte_mask) | wr_data;

    // ------------------------------------------------------------------
    // Eligibility and selection
    // ------------------------------------------------------------------
    wire        in_sleep = (power_mode_i == PM_SLEEP);
    wire        in_idle  = (power_mode_i == PM_IDLE);
    logic [NUM_SRC-1:0] elig;

    // One eligibility term per source: a zero priority field or a clear
    // enable hides the request from every decision below.
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++)
        begin : g_elig
            assign elig[g] = flag_q[g] & enable_q[g]
                           & (source_priority_regs_q[g*PRIO_STRIDE +: PRIO_W] != '0)
                           & (~in_sleep | src_sleep_ok_i[g]);
        end
    endgenerate

    logic                 best_any;
    logic [SRC_ID_W-1:0]  best_id;
    logic [PRIO_W-1:0]    best_prio;

    prio_select prio_select_inst
    (
        .elig_i (elig),
        .prio_i (source_priority_regs_q),
        .any_o  (best_any),
        .id_o   (best_id),
        .prio_o (best_prio)
    );

    // ------------------------------------------------------------------
    // Coalescing decisions
    // ------------------------------------------------------------------
    // Zero coalescing priority turns the timer off; nothing is held back.
    wire coalesce_on  = (coalescing_priority_q != RST_TPC);
    wire coalesce_hit = coalesce_on & best_any & (best_prio < coalescing_priority_q);
    wire released     = (tmr_state_q == TMR_RELEASED);
    wire held         = coalesce_hit & ~released;
    wire above_ipl    = best_any & (best_prio > cpu_ipl_i);
    wire timer_zero   = (proximity_timeout_q == RST_RELOAD);

    // Delivery needs the core's global enable; debug halt blocks all of it.
    wire deliver      = above_ipl & ~held & global_ie_i & ~debug_mode_i;

    // Run wake: an unheld request above the processor level; once the
    // timer releases, the held request goes to Run as well.
    wire run_cond     = above_ipl & ~held & (in_sleep | in_idle);
    // Idle wake only out of Sleep: at/below level, or held by coalescing.
    wire idle_cond    = in_sleep & best_any & ~run_cond;

    // ------------------------------------------------------------------
    // Proximity timer next state
    // ------------------------------------------------------------------
    // The timer reloads on a coalescing hit while off, counts to zero and
    // then releases the queue until no eligible request remains.
    always_comb
    begin
        tmr_state_d = tmr_state_q;
        timer_d     = proximity_timeout_q;
        case (tmr_state_q)
            TMR_OFF:
            begin
                if (coalesce_hit)
                begin
                    tmr_state_d = TMR_COUNT;
                    timer_d     = proximity_reload_value_q;
                end
            end
            TMR_COUNT:
            begin
                if (!coalesce_on)
                begin
                    tmr_state_d = TMR_OFF;
                end
                else if (timer_zero)
                begin
                    tmr_state_d = TMR_RELEASED;
                end
                else
                begin
                    timer_d = proximity_timeout_q - 32'h0000_0001;
                end
            end
            TMR_RELEASED:
            begin
                // The queue drains in priority order through the selector.
                if (!best_any)
                begin
                    tmr_state_d = TMR_OFF;
                end
            end
            default:
            begin
                tmr_state_d = TMR_OFF;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Freeze control
    // ------------------------------------------------------------------
    wire debug_entry   = debug_mode_i & ~debug_prev_q;
    wire freeze_wr     = bus_wr & hit_ctrl & debug_mode_i & sel_i[1];
    wire freeze_rd_val = debug_entry ? freeze_cfg_q : (debug_mode_i & freeze_live_q);

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    wire [31:0] rd_ctrl   = {17'h00000, freeze_rd_val, 11'h000, coalescing_priority_q};
    wire [31:0] rd_status = ({31'h0, best_any} << STAT_ANY_BIT)
                          | ({29'h0, best_prio} << STAT_PRIO_LSB)
                          | ({29'h0, best_id} << STAT_ID_LSB)
                          | ({30'h0, tmr_state_q} << STAT_TMR_LSB)
                          | ({30'h0, power_mode_i} << STAT_PM_LSB);
    logic [31:0] rd_data;

    // Unmapped offsets answer with zero data so the bus never hangs.
    always_comb
    begin
        case (adr_i)
            OFS_CTRL:   rd_data = rd_ctrl;
            OFS_RELOAD: rd_data = proximity_reload_value_q;
            OFS_TIMER:  rd_data = proximity_timeout_q;
            OFS_ENABLE: rd_data = {24'h000000, enable_q};
            OFS_PRIO:   rd_data = source_priority_regs_q;
            OFS_PEND:   rd_data = {24'h000000, flag_q};
            OFS_STATUS: rd_data = rd_status;
            default:    rd_data = RST_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    // One wait state: ack comes the edge after the request is seen and
    // drops the next edge, which also spaces back-to-back requests.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= RST_ZERO;
        end
        else
        begin
            ack_o <= bus_req;
            dat_o <= bus_req ? rd_data : RST_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // All state goes back to reset values on the shared system reset.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            coalescing_priority_q    <= RST_TPC;
            proximity_reload_value_q <= RST_RELOAD;
            enable_q                 <= RST_ENABLE;
            source_priority_regs_q   <= RST_PRIO;
        end
        else
        begin
            if (bus_wr && hit_ctrl)
            begin
                coalescing_priority_q <= ctrl_merge[CTRL_TPC_LSB +: PRIO_W];
            end
            if (bus_wr && hit_reload)
            begin
                proximity_reload_value_q <= rel_merge;
            end
            if (bus_wr && hit_enable)
            begin
                enable_q <= en_merge[NUM_SRC-1:0];
            end
            if (bus_wr && hit_prio)
            begin
                source_priority_regs_q <= prio_merge;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request flags
    // ------------------------------------------------------------------
    // Flags are write-one-to-clear; a request in the clearing cycle wins,
    // so no event is lost. Delivery never clears a flag: software does it
    // once the cause is gone, otherwise the source would fire again.
    wire [NUM_SRC-1:0] flag_clr = (bus_wr && hit_pend) ? wr_data[NUM_SRC-1:0] : '0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag_q <= '0;
        end
        else
        begin
            flag_q <= (flag_q & ~flag_clr) | src_req_i;
        end
    end

    // ------------------------------------------------------------------
    // Proximity timer registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tmr_state_q         <= TMR_OFF;
            proximity_timeout_q <= RST_RELOAD;
        end
        else
        begin
            tmr_state_q         <= tmr_state_d;
            proximity_timeout_q <= timer_d;
        end
    end

    // ------------------------------------------------------------------
    // Freeze registers
    // ------------------------------------------------------------------
    // The written value is only staged; the live copy is taken at debug
    // entry, so a change made in a debug session waits for the next one.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            freeze_cfg_q  <= 1'b0;
            freeze_live_q <= 1'b0;
            debug_prev_q  <= 1'b0;
        end
        else
        begin
            debug_prev_q <= debug_mode_i;
            if (freeze_wr)
            begin
                freeze_cfg_q <= ctrl_merge[CTRL_FREEZE_BIT];
            end
            if (debug_entry)
            begin
                freeze_live_q <= freeze_cfg_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs to core and power manager
    // ------------------------------------------------------------------
    // The identity and priority follow the selector in every delivery cycle, so after
    // debug exit or timer expiry the highest pending source is shown first.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o       <= 1'b0;
            irq_id_o    <= '0;
            irq_prio_o  <= '0;
            wake_idle_o <= 1'b0;
            wake_run_o  <= 1'b0;
            freeze_o    <= 1'b0;
        end
        else
        begin
            irq_o       <= deliver;
            irq_id_o    <= deliver ? best_id : '0;
            irq_prio_o  <= deliver ? best_prio : '0;
            wake_idle_o <= idle_cond;
            wake_run_o  <= run_cond;
            freeze_o    <= freeze_rd_val;
        end
    end

endmodule

// ---- verilog/wake_ctrl_pkg.sv ----
// Constants and types shared by the interrupt wake and debug control block.
package wake_ctrl_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_SRC        = 8;
    localparam int SRC_ID_W       = 3;
    localparam int PRIO_W         = 3;
    localparam int PRIO_STRIDE    = 4;
    localparam int TIMER_W        = 32;

    // ------------------------------------------------------------------
    // Register byte offsets (word index in address bits 4:2)
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_RELOAD  = 5'h04;
    localparam logic [4:0] OFS_TIMER   = 5'h08;
    localparam logic [4:0] OFS_ENABLE  = 5'h0c;
    localparam logic [4:0] OFS_PRIO    = 5'h10;
    localparam logic [4:0] OFS_PEND    = 5'h14;
    localparam logic [4:0] OFS_STATUS  = 5'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_TPC_LSB    = 0;
    localparam int CTRL_FREEZE_BIT = 14;
    localparam int STAT_PM_LSB     = 0;
    localparam int STAT_TMR_LSB    = 4;
    localparam int STAT_ID_LSB     = 8;
    localparam int STAT_PRIO_LSB   = 12;
    localparam int STAT_ANY_BIT    = 16;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [PRIO_W-1:0]  RST_TPC    = 3'h0;
    localparam logic [TIMER_W-1:0] RST_RELOAD = 32'h0000_0000;
    localparam logic [NUM_SRC-1:0] RST_ENABLE = 8'h00;
    localparam logic [31:0]        RST_PRIO   = 32'h0000_0000;
    localparam logic [31:0]        RST_ZERO   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PM_RUN   = 2'b00,
        PM_IDLE  = 2'b01,
        PM_SLEEP = 2'b10
    } power_mode_t;

    typedef enum logic [1:0]
    {
        TMR_OFF      = 2'b00,
        TMR_COUNT    = 2'b01,
        TMR_RELEASED = 2'b10
    } tmr_state_t;

endpackage

// ---- verilog/prio_select.sv ----
// Picks the highest priority eligible source; lowest index wins a tie.
`timescale 1ns/1ps

module prio_select
    import wake_ctrl_pkg::*;
(
    input  wire logic [NUM_SRC-1:0]  elig_i,
    input  wire logic [31:0]         prio_i,
    output logic                     any_o,
    output logic [SRC_ID_W-1:0]      id_o,
    output logic [PRIO_W-1:0]        prio_o
);

    // Linear scan; a strictly higher priority replaces the current pick,
    // so equal priorities keep the lower index.
    always_comb
    begin
        any_o  = 1'b0;
        id_o   = '0;
        prio_o = '0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (elig_i[i] && (!any_o || prio_i[i*PRIO_STRIDE +: PRIO_W] > prio_o))
            begin
                any_o  = 1'b1;
                id_o   = SRC_ID_W'(i);
                prio_o = prio_i[i*PRIO_STRIDE +: PRIO_W];
            end
        end
    end

endmodule

// ---- sim/wake_ctrl_asserts.sv ----
// Concurrent checks on the ports of the wake control block.
`timescale 1ns/1ps

module wake_ctrl_asserts
    import wake_ctrl_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic [31:0]       dat_o,
    input  wire logic              ack_o,
    input  wire logic              global_ie_i,
    input  wire logic              debug_mode_i,
    input  wire logic [1:0]        power_mode_i,
    input  wire logic              irq_o,
    input  wire logic [SRC_ID_W-1:0] irq_id_o,
    input  wire logic [PRIO_W-1:0] irq_prio_o,
    input  wire logic              wake_idle_o,
    input  wire logic              wake_run_o,
    input  wire logic              freeze_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    a_ack_after_take: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered next cycle");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_dat_quiet_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data outside ack cycle");

    // ------------------------------------------------------------------
    // Delivery and wake
    // ------------------------------------------------------------------
    a_debug_holds_irq: assert property (debug_mode_i |=> !irq_o)
        else $error("interrupt delivered in debug halt");
    a_global_gates_irq: assert property (!global_ie_i |=> !irq_o)
        else $error("interrupt delivered with global enable clear");
    a_irq_prio_live: assert property (irq_o |-> irq_prio_o != 3'h0)
        else $error("zero priority delivered");
    a_irq_fields_zero: assert property (!irq_o |-> irq_id_o == 3'h0 && irq_prio_o == 3'h0)
        else $error("interrupt fields set without request");
    a_wake_apart: assert property (!(wake_idle_o && wake_run_o))
        else $error("both wake outputs high");
    a_idle_from_sleep: assert property (wake_idle_o |-> $past(power_mode_i) == PM_SLEEP)
        else $error("idle wake outside sleep");
    a_run_from_low: assert property (wake_run_o |-> $past(power_mode_i) inside {PM_SLEEP, PM_IDLE})
        else $error("run wake outside sleep or idle");
    a_freeze_in_debug: assert property (freeze_o |-> $past(debug_mode_i))
        else $error("freeze in force outside debug");

    c_irq_seen: cover property (irq_o);
    c_idle_wake: cover property (wake_idle_o);
    c_run_wake: cover property (wake_run_o);
    c_freeze_seen: cover property (freeze_o);
endmodule

bind wake_ctrl wake_ctrl_asserts wake_ctrl_asserts_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
    .dat_o, .ack_o, .global_ie_i, .debug_mode_i, .power_mode_i, .irq_o, .irq_id_o,
    .irq_prio_o, .wake_idle_o, .wake_run_o, .freeze_o);

// ---- sim/power_mgr_model.sv ----
// Power mode manager that moves the device mode on the wake outputs.
`timescale 1ns/1ps

module power_mgr_model
    import wake_ctrl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       set_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       wake_idle_i,
    input  wire logic       wake_run_i,
    output logic [1:0]      power_mode_o
);
    logic [1:0] mode_q;
    logic [1:0] mode_d;

    // A commanded mode wins; a wake never lowers the mode, so Run stays Run.
    assign mode_d = set_i ? mode_i
                  : wake_run_i ? PM_RUN
                  : (wake_idle_i && mode_q == PM_SLEEP) ? PM_IDLE : mode_q;
    assign power_mode_o = mode_q;

    // Mode register, back to Run on reset.
    always_ff @(posedge clk_i)
        mode_q <= rst_i ? 2'h0 : mode_d;
endmodule

// ---- sim/wake_ctrl_bench.sv ----
// Self-checking bench for the wake control block.
`timescale 1ns/1ps

module wake_ctrl_bench
    import wake_ctrl_pkg::*;
;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, pm_set = 0;
    logic        debug_mode_i = 0, global_ie_i = 1, ack_o, irq_o, wake_idle_o;
    logic        wake_run_o, freeze_o;
    logic [4:0]  adr_i = 0;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 0, dat_o, rd_q, irq_w;
    logic [7:0]  src_req_i = 0, src_sleep_ok_i = 8'hff;
    logic [2:0]  cpu_ipl_i = 3'h2, irq_id_o, irq_prio_o;
    logic [1:0]  pm_mode = 0, power_mode_i;
    int          bad_count = 0, total_checks = 0, cycles = 0, n;

    assign irq_w = {25'h0, irq_o, irq_id_o, irq_prio_o};

    wake_ctrl wake_ctrl_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .src_req_i, .src_sleep_ok_i, .global_ie_i, .cpu_ipl_i,
        .debug_mode_i, .power_mode_i, .irq_o, .irq_id_o, .irq_prio_o, .wake_idle_o,
        .wake_run_o, .freeze_o);
    power_mgr_model power_mgr_model_inst (.clk_i, .rst_i, .set_i(pm_set), .mode_i(pm_mode),
        .wake_idle_i(wake_idle_o), .wake_run_i(wake_run_o), .power_mode_o(power_mode_i));

    // ------------------------------------------------------------------
    // Clock, hang guard and shared tasks
    // ------------------------------------------------------------------
    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    // The run needs well under a thousand cycles; a stuck wait ends here.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request stands until ack is seen at an edge.
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1)
            @(posedge clk_i);
        rd_q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd_q, exp);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    task automatic pulse(input int idx);
        @(posedge clk_i);
        src_req_i <= 8'h01 << idx;
        @(posedge clk_i);
        src_req_i <= 8'h00;
    endtask

    task automatic mode(input logic [1:0] m);
        @(posedge clk_i);
        pm_set  <= 1'b1;
        pm_mode <= m;
        @(posedge clk_i);
        pm_set  <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(5'(i * 4), 32'h0);
        // Source 1 prio 2, 3 prio 5, 5 prio 1; source 0 has prio 0, 2 (prio 6) is disabled.
        wb(1'b1, OFS_PRIO, 32'h0010_5620);
        wb(1'b1, OFS_ENABLE, 32'h0000_002f);
        wb(1'b1, OFS_ENABLE, 32'h0000_002b);
        @(posedge clk_i);
        global_ie_i <= 1'b0;
        pulse(3);
        tick(4);
        chk(irq_w, 32'h0);
        @(posedge clk_i);
        global_ie_i <= 1'b1;
        tick(3);
        chk(irq_w, 32'h5d);
        wb(1'b1, OFS_PEND, 32'h08);
        mode(PM_SLEEP);
        src_sleep_ok_i <= 8'hf7;
        pulse(0);
        pulse(2);
        pulse(3);
        tick(6);
        chk(power_mode_i, PM_SLEEP);
        @(posedge clk_i);
        src_sleep_ok_i <= 8'hff;
        tick(6);
        chk(power_mode_i, PM_RUN);
        wb(1'b1, OFS_PEND, 32'hff);
        mode(PM_SLEEP);
        pulse(1);
        tick(6);
        chk(power_mode_i, PM_IDLE);
        chk(irq_w, 32'h0);
        rd(OFS_PEND, 32'h02);
        cpu_ipl_i <= 3'h1;
        tick(6);
        chk(power_mode_i, PM_RUN);
        chk(irq_w, 32'h4a);
        // Debug halt holds both requests, then they come out highest first.
        @(posedge clk_i);
        debug_mode_i <= 1'b1;
        cpu_ipl_i    <= 3'h0;
        pulse(3);
        tick(4);
        chk(irq_w, 32'h0);
        wb(1'b1, OFS_CTRL, 32'h4000);
        rd(OFS_CTRL, 32'h0);
        chk(freeze_o, 1'b0);
        debug_mode_i <= 1'b0;
        tick(3);
        chk(irq_w, 32'h5d);
        wb(1'b1, OFS_PEND, 32'h08);
        tick(3);
        chk(irq_w, 32'h4a);
        rd(OFS_CTRL, 32'h0);
        wb(1'b1, OFS_CTRL, 32'h0);
        debug_mode_i <= 1'b1;
        tick(3);
        rd(OFS_CTRL, 32'h4000);
        chk(freeze_o, 1'b1);
        wb(1'b1, OFS_CTRL, 32'h3);
        debug_mode_i <= 1'b0;
        wb(1'b1, OFS_PEND, 32'hff);
        // Coalescing: two low requests wait out a reload of 20 from Sleep.
        wb(1'b1, OFS_RELOAD, 32'd20);
        mode(PM_SLEEP);
        pulse(5);
        pulse(1);
        tick(6);
        chk(power_mode_i, PM_IDLE);
        chk(wake_run_o, 1'b0);
        chk(irq_w, 32'h0);
        n = 0;
        while (wake_run_o !== 1'b1 && n < 60)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(wake_run_o, 1'b1);
        tick(6);
        chk(irq_w, 32'h4a);
        wb(1'b1, OFS_PEND, 32'h02);
        tick(3);
        chk(irq_w, 32'h69);
        wb(1'b1, OFS_PEND, 32'hff);
        wb(1'b1, OFS_CTRL, 32'h0);
        mode(PM_IDLE);
        pulse(1);
        tick(6);
        chk(power_mode_i, PM_RUN);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_ENABLE, 32'h0);
        rd(OFS_RELOAD, 32'h0);
        give_verdict();
    end
endmodule
